/* File: sim/hrc_node_model.sv */
// behavioural network node: drives the node ready line with contact bounce
`timescale 1ns/1ps
module hrc_node_model
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic node_up,
	input wire logic host_ready_relay,
	output logic node_ready_line,
	output int resync_seen
);
	logic [2:0] bounce_q;
	logic relay_q;
	int resync_q;
	////////////////////////////////////////////////////////////////
	// node_up rising starts six toggles of the line, so the host sees several drops
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bounce_q <= 3'h0;
			relay_q <= 1'b0;
			resync_q <= 0;
			node_ready_line <= 1'b0;
		end
		else
		begin
			relay_q <= host_ready_relay;
			if (relay_q && !host_ready_relay)
				resync_q <= resync_q + 1;
			if (!node_up)
			begin
				bounce_q <= 3'h6;
				node_ready_line <= 1'b0;
			end
			else if (bounce_q != 3'h0)
			begin
				bounce_q <= bounce_q - 3'h1;
				node_ready_line <= !node_ready_line;
			end
			else
				node_ready_line <= 1'b1;
		end
	end
	// count of host-ready drops seen, so the bench can tell a restart reached the node
	assign resync_seen = resync_q;
endmodule

/* File: sim/hrc_top_tb.sv */
// self-checking bench for the ready line and link error control block
`timescale 1ns/1ps
module hrc_top_tb;
	import hrc_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic node_ready_line;
	logic node_up = 1'b1;
	logic hbo_in = 1'b0;
	logic rnb_in = 1'b0;
	logic relay;
	logic hbo_out;
	logic rnb_out;
	logic irq;
	logic [31:0] rd;
	logic rerr;
	int resync;
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;
	localparam int STAB = 20;
	hrc_top #(.STAB_CYC(HRC_CNT_W'(STAB))) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .node_ready_line(node_ready_line),
		.host_bit_offered_in(hbo_in), .request_next_node_bit_in(rnb_in),
		.host_ready_relay(relay), .host_bit_offered_strobe(hbo_out),
		.request_next_node_bit(rnb_out), .irq(irq));
	hrc_node_model node (.pclk(pclk), .presetn(presetn), .node_up(node_up),
		.host_ready_relay(relay), .node_ready_line(node_ready_line), .resync_seen(resync));
	always #5 pclk = !pclk;
	////////////////////////////////////////////////////////////////
	// hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			err_total++;
			conclude();
		end
	end
	task automatic conclude();
		if (err_total == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer; the request stands until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask
	////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		idle(3);
		presetn <= 1'b1;
		idle(20);
		apb(1'b0, HRC_CTRL_OFF, 0);
		chk(rd, 32'h0);
		chk(relay, 1'b0);
		apb(1'b0, HRC_STAT_OFF, 0);
		chk(rd & 32'h7, 32'h7);
		apb(1'b1, HRC_CTRL_OFF, 32'h1);
		apb(1'b0, HRC_WAIT_OFF, 0);
		chk(rd, STAB - 1);
		chk(relay, 1'b1);
		apb(1'b1, HRC_ERRCLR_OFF, 32'h1);
		apb(1'b0, HRC_STAT_OFF, 0);
		chk(rd & 32'h7, 32'h5);
		chk(rd[HRC_STAT_READY_BIT], 1'b0);
		apb(1'b1, HRC_ERRCLR_OFF, 32'h2);
		apb(1'b0, HRC_STAT_OFF, 0);
		chk(rd & 32'h7, 32'h1);
		idle(STAB + 5);
		apb(1'b0, HRC_STAT_OFF, 0);
		chk(rd[HRC_STAT_READY_BIT], 1'b1);
		// node loss raises the enabled event; regain stays masked
		apb(1'b1, HRC_IRQ_EN_OFF, 32'h1);
		apb(1'b1, HRC_IRQ_CLR_OFF, 32'h7);
		idle(1);
		chk(irq, 1'b0);
		node_up <= 1'b0;
		idle(8);
		chk(irq, 1'b1);
		apb(1'b0, HRC_STAT_OFF, 0);
		chk(rd & 32'h7, 32'h6);
		apb(1'b1, HRC_IRQ_CLR_OFF, 32'h1);
		idle(1);
		chk(irq, 1'b0);
		node_up <= 1'b1;
		idle(20);
		chk(irq, 1'b0);
		apb(1'b0, HRC_IRQ_STAT_OFF, 0);
		chk(rd & 32'h3, 32'h2);
		// restart with hardware stabilisation; clears lose while host is off
		apb(1'b1, HRC_CTRL_OFF, 32'h0);
		apb(1'b1, HRC_ERRCLR_OFF, 32'h3);
		apb(1'b0, HRC_STAT_OFF, 0);
		chk(rd & 32'h6, 32'h6);
		hbo_in <= 1'b1;
		rnb_in <= 1'b1;
		apb(1'b1, HRC_CTRL_OFF, 32'h3);
		idle(3);
		chk({hbo_out, rnb_out}, 2'h0);
		idle(STAB + 5);
		chk({hbo_out, rnb_out}, 2'h3);
		apb(1'b0, HRC_STAT_OFF, 0);
		chk(rd[HRC_STAT_STABLE_BIT], 1'b1);
		apb(1'b0, HRC_IRQ_STAT_OFF, 0);
		chk(rd[HRC_IRQ_STABLE_BIT], 1'b1);
		// shared mode: a single clear bit empties both flags
		apb(1'b1, HRC_CTRL_OFF, 32'h7);
		apb(1'b1, HRC_ERRCLR_OFF, 32'h1);
		apb(1'b0, HRC_STAT_OFF, 0);
		chk(rd & 32'h6, 32'h0);
		// second restart in shared mode, cleared through the transmit bit alone
		apb(1'b1, HRC_CTRL_OFF, 32'h6);
		apb(1'b1, HRC_CTRL_OFF, 32'h7);
		apb(1'b0, HRC_STAT_OFF, 0);
		chk(rd & 32'h6, 32'h6);
		apb(1'b1, HRC_ERRCLR_OFF, 32'h2);
		apb(1'b0, HRC_STAT_OFF, 0);
		chk(rd & 32'h6, 32'h0);
		chk(resync, 2);
		apb(1'b0, 8'h1c, 0);
		chk(rerr, 1'b1);
		chk(rd, 32'h0);
		chk(pready, 1'b1);
		conclude();
	end
endmodule

/* File: src/hrc_oneshot.sv */
// integrating one-shot: output rises after input held high for the full count
`timescale 1ns/1ps
module hrc_oneshot
	import hrc_pkg::*;
#(
	parameter logic [HRC_CNT_W-1:0] HOLD_CYC = HRC_CNT_W'(HRC_STAB_CYC)
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic level_in,
	output logic stable_out
);
	typedef struct packed
	{
		logic [HRC_CNT_W-1:0] cnt;
		logic done;
	} hrc_os_s;
	hrc_os_s st_q;
	hrc_os_s st_d;

	// any low restarts integration, so bounce never lets the output rise early
	always_comb
	begin
		st_d = st_q;
		if (!level_in)
		begin
			st_d.cnt = '0;
			st_d.done = 1'b0;
		end
		else if (st_q.cnt >= HOLD_CYC - 1'b1)
		begin
			st_d.done = 1'b1;
		end
		else
		begin
			st_d.cnt = st_q.cnt + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign stable_out = st_q.done;
endmodule

/* File: src/hrc_pkg.sv */
// package of constants for the host ready line and link error control block
package hrc_pkg;
	// register byte offsets
	localparam logic [7:0] HRC_CTRL_OFF = 8'h00;
	localparam logic [7:0] HRC_STAT_OFF = 8'h04;
	localparam logic [7:0] HRC_ERRCLR_OFF = 8'h08;
	localparam logic [7:0] HRC_IRQ_STAT_OFF = 8'h0c;
	localparam logic [7:0] HRC_IRQ_EN_OFF = 8'h10;
	localparam logic [7:0] HRC_IRQ_CLR_OFF = 8'h14;
	localparam logic [7:0] HRC_WAIT_OFF = 8'h18;
	// control register fields
	localparam int HRC_CTRL_READY_BIT = 0;
	localparam int HRC_CTRL_HWSTAB_BIT = 1;
	localparam int HRC_CTRL_SHARED_BIT = 2;
	// status register fields
	localparam int HRC_STAT_NODE_BIT = 0;
	localparam int HRC_STAT_RXERR_BIT = 1;
	localparam int HRC_STAT_TXERR_BIT = 2;
	localparam int HRC_STAT_STABLE_BIT = 3;
	localparam int HRC_STAT_READY_BIT = 4;
	// error clear and interrupt fields
	localparam int HRC_ERR_RX_BIT = 0;
	localparam int HRC_ERR_TX_BIT = 1;
	localparam int HRC_IRQ_W = 3;
	localparam int HRC_IRQ_LOSS_BIT = 0;
	localparam int HRC_IRQ_REGAIN_BIT = 1;
	localparam int HRC_IRQ_STABLE_BIT = 2;
	localparam logic [2:0] HRC_CTRL_RESET = 3'h0;
	// timing: one half second at 100 MHz
	localparam int HRC_CLK_MHZ = 100;
	localparam int HRC_STAB_MS = 500;
	localparam int HRC_STAB_CYC = HRC_STAB_MS * HRC_CLK_MHZ * 1000;
	localparam int HRC_CNT_W = 26;
endpackage

/* File: src/hrc_sync.sv */
// three flip-flop synchroniser with agreement check
`timescale 1ns/1ps
module hrc_sync
	import hrc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic async_in,
	output logic sync_out
);
	typedef struct packed
	{
		logic s1;
		logic s2;
		logic s3;
		logic out;
	} hrc_sync_s;
	hrc_sync_s st_q;
	hrc_sync_s st_d;

	// first stage read only by the second; output moves once stages two and three agree
	always_comb
	begin
		st_d = st_q;
		st_d.s1 = async_in;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		if (st_q.s2 == st_q.s3)
		begin
			st_d.out = st_q.s3;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign sync_out = st_q.out;
endmodule

/* File: src/hrc_top.sv */
// host ready line control, link error flops and apb register slave
// Operation
// [R1] software sets and clears a host-ready flop that drives the host-ready relay output.
// [R2] the node-ready line is readable as status and is no interrupt source itself; the code raises loss and regain interrupt events from its edges.
// [R3] error flops are set while host-ready or node-ready is off.
// [R4] error flops are readable and software-clearable status, not interrupts.
// [R5] reset does not clear the error flops; only a software clear does.
// [R6] receive and transmit error flops are both set and cleared independently; the code sets both together whenever the link is down.
// [R7] a half-second integrating one-shot on host-ready gates both host bit strobes.
// [R8] software stabilisation waits half a second after setting host-ready before transfers.
// [R9] at restart software clears host-ready, waits half a second, then sets it again.
// [R10] the node holds off its strobes until its ready line stops bouncing.
// [R11] after a ready drop each side sends a discardable message and drops its input.
// [R12] the node resynchronises after host-ready drops and rises.
// [R13] the receive driver waits for buffer and node-ready, then checks receive error.
// [R14] on receive error the driver clears the flag and reuses the buffer.
// [R15] on transmit error the driver clears the flag and keeps the message.
// [R16] in shared mode one error flop is copied into the other flag before clearing; the code copies nothing and clears both flops from either clear bit.
// [R17] node-ready is synchronised before it sets errors or status.
`timescale 1ns/1ps
module hrc_top
	import hrc_pkg::*;
#(
	parameter logic [HRC_CNT_W-1:0] STAB_CYC = HRC_CNT_W'(HRC_STAB_CYC)
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic node_ready_line,
	input wire logic host_bit_offered_in,
	input wire logic request_next_node_bit_in,
	output logic host_ready_relay,
	output logic host_bit_offered_strobe,
	output logic request_next_node_bit,
	output logic irq
);
	//////////////////////////////////////////////////////////////////////////////////
	typedef struct packed
	{
		logic host_ready;
		logic hw_stab;
		logic shared_mode;
		logic [HRC_IRQ_W-1:0] irq_stat;
		logic [HRC_IRQ_W-1:0] irq_en;
		logic node_prev;
		logic stable_prev;
		logic [HRC_CNT_W-1:0] wait_cnt;
		logic [31:0] rdata;
		logic strobe_bit;
		logic strobe_req;
	} hrc_top_s;
	hrc_top_s st_q;
	hrc_top_s st_d;
	// error flops sit outside the reset struct: no reset reaches them
	logic rx_err_q;
	logic tx_err_q;
	logic rx_err_d;
	logic tx_err_d;
	logic node_rdy;
	logic stable;
	logic wr;
	logic rd;
	logic link_down;

	// node-ready enters through four flops (three stages and the output flop) before any use
	hrc_sync u_sync
	(
		.pclk(pclk),
		.presetn(presetn),
		.async_in(node_ready_line),
		.sync_out(node_rdy) // R17
	);

	// integrating one-shot fed by the host-ready flop
	hrc_oneshot #(.HOLD_CYC(STAB_CYC)) u_os
	(
		.pclk(pclk),
		.presetn(presetn),
		.level_in(st_q.host_ready),
		.stable_out(stable)
	);

	//////////////////////////////////////////////////////////////////////////////////
	// apb always ready, zero wait states; writes take effect in the access phase
	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign link_down = !st_q.host_ready || !node_rdy; // R3

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	function automatic logic known(input logic [7:0] a);
		known = hit(a, HRC_CTRL_OFF) || hit(a, HRC_STAT_OFF) || hit(a, HRC_ERRCLR_OFF)
			|| hit(a, HRC_IRQ_STAT_OFF) || hit(a, HRC_IRQ_EN_OFF)
			|| hit(a, HRC_IRQ_CLR_OFF) || hit(a, HRC_WAIT_OFF);
	endfunction

	assign pslverr = psel && penable && !known(paddr);

	//////////////////////////////////////////////////////////////////////////////////
	// error flops: set wins over a software clear in the same cycle
	always_comb
	begin
		rx_err_d = rx_err_q;
		tx_err_d = tx_err_q;
		if (wr && hit(paddr, HRC_ERRCLR_OFF))
		begin
			if (pwdata[HRC_ERR_RX_BIT])
			begin
				rx_err_d = 1'b0; // R4 R6 R14
			end
			if (pwdata[HRC_ERR_TX_BIT] || (st_q.shared_mode && pwdata[HRC_ERR_RX_BIT]))
			begin
				tx_err_d = 1'b0; // R15 R16
			end
			if (st_q.shared_mode && pwdata[HRC_ERR_TX_BIT])
			begin
				rx_err_d = 1'b0; // R16
			end
		end
		if (link_down)
		begin
			rx_err_d = 1'b1; // R3 R6 R11
			tx_err_d = 1'b1; // R3 R6 R11
		end
	end

	// no reset on purpose: initialisation must not erase a recorded loss
	always_ff @(posedge pclk)
	begin
		rx_err_q <= rx_err_d; // R5
		tx_err_q <= tx_err_d; // R5
	end

	//////////////////////////////////////////////////////////////////////////////////
	// control, interrupt and read data next state
	always_comb
	begin
		st_d = st_q;
		st_d.node_prev = node_rdy;
		st_d.stable_prev = stable;
		// software wait counter for the half-second restart and settle
		if (st_q.wait_cnt != '0)
		begin
			st_d.wait_cnt = st_q.wait_cnt - 1'b1; // R8 R9
		end
		if (wr && hit(paddr, HRC_CTRL_OFF))
		begin
			st_d.host_ready = pwdata[HRC_CTRL_READY_BIT]; // R1
			st_d.hw_stab = pwdata[HRC_CTRL_HWSTAB_BIT];
			st_d.shared_mode = pwdata[HRC_CTRL_SHARED_BIT];
			if (pwdata[HRC_CTRL_READY_BIT] != st_q.host_ready)
			begin
				st_d.wait_cnt = STAB_CYC; // R8 R9
			end
		end
		if (wr && hit(paddr, HRC_IRQ_EN_OFF))
		begin
			st_d.irq_en = pwdata[HRC_IRQ_W-1:0];
		end
		if (wr && hit(paddr, HRC_IRQ_CLR_OFF))
		begin
			st_d.irq_stat = st_q.irq_stat & ~pwdata[HRC_IRQ_W-1:0];
		end
		// link events, set after clear so a simultaneous event survives
		if (st_q.node_prev && !node_rdy)
		begin
			st_d.irq_stat[HRC_IRQ_LOSS_BIT] = 1'b1;
		end
		if (!st_q.node_prev && node_rdy)
		begin
			st_d.irq_stat[HRC_IRQ_REGAIN_BIT] = 1'b1;
		end
		if (!st_q.stable_prev && stable)
		begin
			st_d.irq_stat[HRC_IRQ_STABLE_BIT] = 1'b1;
		end
		// strobes gated by the one-shot when hardware stabilisation is on
		st_d.strobe_bit = host_bit_offered_in && (stable || !st_q.hw_stab); // R7
		st_d.strobe_req = request_next_node_bit_in && (stable || !st_q.hw_stab); // R7
		// read data captured in setup so it stands through the access phase
		st_d.rdata = '0;
		if (rd)
		begin
			unique case (1'b1)
				hit(paddr, HRC_CTRL_OFF):
				begin
					st_d.rdata[HRC_CTRL_READY_BIT] = st_q.host_ready;
					st_d.rdata[HRC_CTRL_HWSTAB_BIT] = st_q.hw_stab;
					st_d.rdata[HRC_CTRL_SHARED_BIT] = st_q.shared_mode;
				end
				hit(paddr, HRC_STAT_OFF):
				begin
					st_d.rdata[HRC_STAT_NODE_BIT] = node_rdy; // R2
					st_d.rdata[HRC_STAT_RXERR_BIT] = rx_err_q; // R4 R13
					st_d.rdata[HRC_STAT_TXERR_BIT] = tx_err_q; // R4
					st_d.rdata[HRC_STAT_STABLE_BIT] = stable;
					st_d.rdata[HRC_STAT_READY_BIT] = (st_q.wait_cnt == '0);
				end
				hit(paddr, HRC_IRQ_STAT_OFF):
				begin
					st_d.rdata[HRC_IRQ_W-1:0] = st_q.irq_stat;
				end
				hit(paddr, HRC_IRQ_EN_OFF):
				begin
					st_d.rdata[HRC_IRQ_W-1:0] = st_q.irq_en;
				end
				hit(paddr, HRC_WAIT_OFF):
				begin
					st_d.rdata[HRC_CNT_W-1:0] = st_q.wait_cnt;
				end
				default:
				begin
					st_d.rdata = '0;
				end
			endcase
		end
		else if (psel && penable)
		begin
			st_d.rdata = st_q.rdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////
	assign prdata = st_q.rdata;
	assign host_ready_relay = st_q.host_ready; // R1
	assign host_bit_offered_strobe = st_q.strobe_bit;
	assign request_next_node_bit = st_q.strobe_req;
	assign irq = |(st_q.irq_stat & st_q.irq_en); // R2 R4

	//////////////////////////////////////////////////////////////////////////////////
	a_err_on_loss: assert property (@(posedge pclk) disable iff (!presetn)
		link_down |=> rx_err_q && tx_err_q) // R3
		else $error("error flops not set on link loss");
	a_relay_follows: assert property (@(posedge pclk) disable iff (!presetn)
		wr && hit(paddr, HRC_CTRL_OFF)
		|=> host_ready_relay == $past(pwdata[HRC_CTRL_READY_BIT])) // R1
		else $error("relay does not follow control write");
	a_gate_strobe: assert property (@(posedge pclk) disable iff (!presetn)
		st_q.hw_stab && !stable |=> !host_bit_offered_strobe && !request_next_node_bit) // R7
		else $error("strobe passed before stabilisation");
	a_clear_rx: assert property (@(posedge pclk) disable iff (!presetn)
		wr && hit(paddr, HRC_ERRCLR_OFF) && pwdata[HRC_ERR_RX_BIT] && !link_down
		|=> !rx_err_q) // R4
		else $error("receive error clear ignored");
	a_indep_clear: assert property (@(posedge pclk) disable iff (!presetn)
		wr && hit(paddr, HRC_ERRCLR_OFF) && pwdata[HRC_ERR_RX_BIT] && !pwdata[HRC_ERR_TX_BIT]
		&& !st_q.shared_mode && tx_err_q |=> tx_err_q) // R6
		else $error("transmit error cleared by receive clear");
	a_shared_clear: assert property (@(posedge pclk) disable iff (!presetn)
		wr && hit(paddr, HRC_ERRCLR_OFF) && pwdata[HRC_ERR_TX_BIT] && st_q.shared_mode
		&& !link_down |=> !rx_err_q && !tx_err_q) // R16
		else $error("shared clear incomplete");
	a_wait_load: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(host_ready_relay) |-> st_q.wait_cnt == STAB_CYC) // R8 R9
		else $error("settle wait not started");
	a_node_sync: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(node_rdy) |-> $past(node_ready_line, 3)) // R17
		else $error("node ready not synchronised");

	// restart steps: the relay falls, then both error flops record the loss
	sequence s_ready_fall;
		$fell(host_ready_relay);
	endsequence
	sequence s_both_err;
		rx_err_q && tx_err_q;
	endsequence
	a_drop_sets_err: assert property (@(posedge pclk) disable iff (!presetn)
		s_ready_fall |=> s_both_err) // R3 R11 R12
		else $error("host ready drop did not set error flops");
	// flags are sticky: only a clear write may lower them
	a_rx_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		rx_err_q && !(wr && hit(paddr, HRC_ERRCLR_OFF)) |=> rx_err_q) // R4 R5
		else $error("receive error flop lost without clear");
	a_tx_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		tx_err_q && !(wr && hit(paddr, HRC_ERRCLR_OFF)) |=> tx_err_q) // R4 R5
		else $error("transmit error flop lost without clear");
	// open gate must pass both strobes, one cycle later
	a_strobe_pass: assert property (@(posedge pclk) disable iff (!presetn)
		(!st_q.hw_stab || stable) && host_bit_offered_in && request_next_node_bit_in
		|=> host_bit_offered_strobe && request_next_node_bit) // R7
		else $error("strobe blocked with gate open");
	// settle countdown steps by one each cycle until it reaches zero
	a_wait_count: assert property (@(posedge pclk) disable iff (!presetn)
		st_q.wait_cnt != '0 && !(wr && hit(paddr, HRC_CTRL_OFF))
		|=> st_q.wait_cnt == $past(st_q.wait_cnt) - 1'b1) // R8 R9
		else $error("settle countdown skipped a step");
	a_node_status: assert property (@(posedge pclk) disable iff (!presetn)
		rd && hit(paddr, HRC_STAT_OFF) |=> prdata[HRC_STAT_NODE_BIT] == $past(node_rdy)) // R2
		else $error("node ready status not captured");
endmodule
